// ==== test_zsd_droop_servo.sv ====
/* Self-checking bench of the droop and zero-servo block.
   Assumes the encoder model and a short delay step of 32 cycles. */
`timescale 1ns/1ps
`include "zsd_defines.svh"
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); \
    end end
module test_zsd_droop_servo;
    import zsd_pkg::*;
    // ********
    // Bench
    // ********
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, e, enc_a, enc_b;
    logic run_pin = 0, move = 0, up = 0;
    logic [3:0] din = 0, dout;
    zsd_drive_in_type drive_in = '0;
    zsd_drive_out_type drive_out;
    int fail_count = 0, n_compared = 0;
    zsd_droop_servo #(.CYC_PER_STEP(32)) uut (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .run_pin(run_pin), .enc_a(enc_a),
        .enc_b(enc_b), .din(din), .dout(dout), .drive_in(drive_in),
        .drive_out(drive_out));
    zsd_encoder_model enc_model (.clk(clk), .resetn(resetn), .move(move),
        .up(up), .enc_a(enc_a), .enc_b(enc_b));
    initial forever #2.5 clk = ~clk;
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
        @(posedge clk);
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK("read data", x, r)
    endtask : rd
    // Pin sync, state and output registers settle well inside this
    task automatic settle();
        repeat (12) @(posedge clk);
    endtask : settle
    task automatic turn(input int n, input logic u);
        repeat (n) begin
            move <= 1'b1;
            up <= u;
            @(posedge clk);
            move <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask : turn
    task automatic t_regs();
        rd(`ZSD_OFS_DROOP_GAIN, 32'h0);
        rd(`ZSD_OFS_DROOP_DELAY, 32'h5);
        rd(`ZSD_OFS_DROOP_DISABLE, 32'h1);
        rd(`ZSD_OFS_STANDSTILL, 32'h5);
        rd(`ZSD_OFS_HOLD_GAIN, 32'h5);
        rd(`ZSD_OFS_HOLD_WINDOW, 32'ha);
        rd(`ZSD_OFS_INPUT_SELECT, 32'h48);
        rd(`ZSD_OFS_OUTPUT_SELECT, 32'h21);
        rd(`ZSD_OFS_MAX_FREQ, 32'h258);
        apb(1'b1, 12'h030, 32'h1);
        `CHK("unmapped error", 1'b1, e)
        rd(12'h030, 32'h0);
    endtask : t_regs
    task automatic t_droop();
        run_pin <= 1'b1;
        drive_in.freq_ref <= 16'sd600;
        drive_in.torque <= 16'sd1000;
        apb(1'b1, `ZSD_OFS_DROOP_GAIN, 32'h64);
        settle();
        `CHK("speed lags", 1'b1, drive_out.speed_ref > 16'sd540)
        apb(1'b1, `ZSD_OFS_DROOP_DELAY, 32'h0);
        settle();
        `CHK("speed at rated torque", 16'sd540, drive_out.speed_ref)
        drive_in.torque <= 16'sd500;
        settle();
        `CHK("speed at half torque", 16'sd570, drive_out.speed_ref)
        apb(1'b1, `ZSD_OFS_DROOP_DISABLE, 32'h0);
        settle();
        `CHK("speed droop off", 16'sd600, drive_out.speed_ref)
        apb(1'b1, `ZSD_OFS_DROOP_DISABLE, 32'h1);
    endtask : t_droop
    task automatic t_hold();
        drive_in.freq_ref <= 16'sd5;
        din <= 4'h1;
        settle();
        apb(1'b0, `ZSD_OFS_STATUS, 32'h0);
        `CHK("hold at threshold", 1'b0, r[`ZSD_STAT_HOLD])
        drive_in.freq_ref <= 16'sd3;
        settle();
        apb(1'b0, `ZSD_OFS_STATUS, 32'h0);
        `CHK("hold below threshold", 1'b1, r[`ZSD_STAT_HOLD])
        rd(`ZSD_OFS_DISPLACEMENT, 32'h0);
        turn(10, 1'b1);
        settle();
        rd(`ZSD_OFS_DISPLACEMENT, 32'ha);
        `CHK("done at width", 1'b1, dout[0])
        `CHK("holding speed", -16'sd50, drive_out.speed_ref)
        apb(1'b1, `ZSD_OFS_DISPLACEMENT, 32'h5);
        rd(`ZSD_OFS_DISPLACEMENT, 32'ha);
        turn(1, 1'b1);
        settle();
        `CHK("done past width", 1'b0, dout[0])
        turn(1, 1'b0);
        settle();
        `CHK("done back inside", 1'b1, dout[0])
        apb(1'b1, `ZSD_OFS_OUTPUT_SELECT, 32'h2100);
        settle();
        `CHK("done on output 1", 4'h2, dout)
        apb(1'b1, `ZSD_OFS_OUTPUT_SELECT, 32'h21);
        settle();
        din <= 4'h0;
        settle();
        `CHK("done without command", 1'b0, dout[0])
        din <= 4'h1;
        settle();
        rd(`ZSD_OFS_DISPLACEMENT, 32'h0);
    endtask : t_hold
    task automatic t_run_off();
        run_pin <= 1'b0;
        settle();
        `CHK("output enable", 1'b0, drive_out.enable)
        apb(1'b0, `ZSD_OFS_STATUS, 32'h0);
        `CHK("hold after run off", 1'b0, r[`ZSD_STAT_HOLD])
        `CHK("done after run off", 1'b0, dout[0])
    endtask : t_run_off
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_droop();
        t_hold();
        t_run_off();
        give_verdict();
    end
endmodule : test_zsd_droop_servo

// ==== zsd_checker_sva.sv ====
/* Checker of the droop and zero-servo block, bound to its top module.
   Assumes the default input and output selects (command on din[0],
   completion on dout[0]) and the one-wait-state APB slave. */
`timescale 1ns/1ps
module zsd_checker_sva #(
    parameter int NUM_DI = 4,
    parameter int NUM_DO = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and core
    input wire logic run_pin,
    input wire logic [NUM_DI-1:0] din,
    input wire logic [NUM_DO-1:0] dout,
    input wire zsd_pkg::zsd_drive_out_type drive_out
);
    import zsd_pkg::*;
    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence access_wait;
        psel && penable && !pready;
    endsequence
    // Sync stages plus the output register need four quiet samples; five are used
    sequence cmd_gone;
        !din[0] [*5];
    endsequence
    sequence run_gone;
        !run_pin [*6];
    endsequence
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    a_apb_wait: assert property (access_wait |=> pready)
        else $error("pready late in access phase");
    a_err_unmapped: assert property (pready && paddr > 12'h02c
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read bus busy outside answer");
    a_done_cmd_off: assert property (cmd_gone |-> !dout[0])
        else $error("completion on without command");
    a_done_in_run: assert property (dout[0] |-> drive_out.enable)
        else $error("completion on with output off");
    a_run_off: assert property (run_gone |-> !drive_out.enable)
        else $error("output on without run");
    a_run_on: assert property (run_pin [*6] |-> drive_out.enable)
        else $error("output off with run");
    a_idle_zero: assert property (!drive_out.enable [*3]
        |-> drive_out.speed_ref == 16'sh0000)
        else $error("speed command while output off");
endmodule : zsd_checker_sva

bind zsd_droop_servo zsd_checker_sva #(.NUM_DI(NUM_DI), .NUM_DO(NUM_DO))
    u_chk (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_pin(run_pin), .din(din), .dout(dout), .drive_out(drive_out));

// ==== zsd_defines.svh ====
/*
 * Constants of the droop and zero-servo block: register offsets, reset
 * values, function codes and timing figures.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ZSD_DEFINES_SVH
`define ZSD_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ZSD_OFS_DROOP_GAIN    12'h000
`define ZSD_OFS_DROOP_DELAY   12'h004
`define ZSD_OFS_DROOP_DISABLE 12'h008
`define ZSD_OFS_STANDSTILL    12'h00c
`define ZSD_OFS_HOLD_GAIN     12'h010
`define ZSD_OFS_HOLD_WINDOW   12'h014
`define ZSD_OFS_INPUT_SELECT  12'h018
`define ZSD_OFS_OUTPUT_SELECT 12'h01c
`define ZSD_OFS_MAX_FREQ      12'h020
`define ZSD_OFS_STATUS        12'h024
`define ZSD_OFS_DISPLACEMENT  12'h028
`define ZSD_OFS_SPEED_OUT     12'h02c

// ****************************************************************
// Reset values
// ****************************************************************
// Droop gain in 0.1 % steps: 0.0 %
`define ZSD_RST_DROOP_GAIN    16'h0000
// Droop delay in 10 ms steps: 0.05 s
`define ZSD_RST_DROOP_DELAY   16'h0005
// Nonzero lets droop act; zero disables it
`define ZSD_RST_DROOP_DISABLE 8'h01
// Standstill threshold in 0.1 Hz steps: 0.5 Hz
`define ZSD_RST_STANDSTILL    16'h0005
`define ZSD_RST_HOLD_GAIN     16'h0005
// Completion width in encoder pulses times 4
`define ZSD_RST_HOLD_WINDOW   16'h000a
// Input 0 carries the zero-servo command, output 0 the completion
`define ZSD_RST_INPUT_SELECT  32'h0000_0048
`define ZSD_RST_OUTPUT_SELECT 32'h0000_0021
// Maximum output frequency in 0.1 Hz steps: 60.0 Hz
`define ZSD_RST_MAX_FREQ      16'h0258

// ****************************************************************
// Function codes and status fields
// ****************************************************************
`define ZSD_FN_HOLD_CMD       8'h48
`define ZSD_FN_HOLD_DONE      8'h21
`define ZSD_STAT_RUN          0
`define ZSD_STAT_HOLD         1
`define ZSD_STAT_DONE         2
`define ZSD_STAT_DROOP        3
`define ZSD_STAT_CMD          4

// ****************************************************************
// Scaling and timing
// ****************************************************************
// Gain (0.1 %) times torque (0.1 % of rated) needs this divisor
`define ZSD_DROOP_DIV         50'sd1000000
`define ZSD_CLK_HZ            200000000
`define ZSD_DELAY_STEP_MS     10
// Filter moves 1/16 of the error per tick, so 16 ticks make the lag
`define ZSD_FILTER_SHIFT      4
`define ZSD_CYC_PER_STEP \
    (`ZSD_CLK_HZ / 1000 * `ZSD_DELAY_STEP_MS)

`endif

// ==== zsd_droop_servo.sv ====
/*
 * Droop load sharing and zero-servo position hold, with an APB slave
 * for the settings and monitors.
 * Assumes the drive inputs come from the control core on clk, while the
 * encoder lines, digital inputs and run command arrive from pins.
 */
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "zsd_defines.svh"

module zsd_droop_servo #(
    parameter int NUM_DI = 4,
    parameter int NUM_DO = 4,
    parameter int CYC_PER_STEP = `ZSD_CYC_PER_STEP
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic run_pin,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic [NUM_DI-1:0] din,
    output logic [NUM_DO-1:0] dout,
    // Control core
    input wire zsd_pkg::zsd_drive_in_type drive_in,
    output zsd_pkg::zsd_drive_out_type drive_out
);
    import zsd_pkg::*;

    // ****************************************************************
    // Settings
    // ****************************************************************
    logic [15:0] droop_gain_setting;
    logic [15:0] droop_delay_setting;
    logic [7:0] droop_disable_setting;
    logic [15:0] standstill_threshold_setting;
    logic [15:0] hold_loop_gain_setting;
    logic [15:0] hold_window_setting;
    logic [31:0] multifunction_input_select;
    logic [31:0] multifunction_output_select;
    logic [15:0] max_freq_setting;

    logic [NUM_DI-1:0] din_meta;
    logic [NUM_DI-1:0] din_sync;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [1:0] enc_prev;
    logic signed [31:0] enc_count;
    logic signed [31:0] start_pos;
    logic signed [31:0] displacement;
    logic [31:0] disp_mag;
    zsd_state_type state;
    zsd_state_type next_state;
    logic hold_cmd;
    logic hold_done;
    logic below_standstill;
    logic droop_on;
    logic signed [32:0] droop_p1;
    logic signed [49:0] droop_p2;
    logic signed [15:0] droop_raw;
    logic signed [15:0] droop_filt;
    logic signed [47:0] hold_prod;
    logic [15:0] ref_mag;
    logic [NUM_DI-1:0] din_hit;
    logic access;
    logic [31:0] read_word;
    logic read_ok;

    function automatic logic signed [15:0] zsd_clip16(
        input logic signed [49:0] value
    );
        if (value > 50'sd32767) begin
            return 16'sh7fff;
        end else if (value < -50'sd32768) begin
            return 16'sh8000;
        end else begin
            return value[15:0];
        end
    endfunction : zsd_clip16

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            din_meta <= '0;
            din_sync <= '0;
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            din_meta <= din;
            din_sync <= din_meta;
            pin_meta <= {run_pin, enc_b, enc_a};
            pin_sync <= pin_meta;
        end
    end

    // ****************************************************************
    // Multifunction input and output routing
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_DI; gi++) begin : g_din
            assign din_hit[gi] = din_sync[gi] &&
                multifunction_input_select[8*gi +: 8] == `ZSD_FN_HOLD_CMD;
        end
        for (gi = 0; gi < NUM_DO; gi++) begin : g_dout
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    dout[gi] <= 1'b0;
                end else begin
                    dout[gi] <= hold_done && next_state == ZSD_HOLD &&
                        multifunction_output_select[8*gi +: 8] ==
                        `ZSD_FN_HOLD_DONE;
                end
            end
        end
    endgenerate

    assign hold_cmd = |din_hit;

    // ****************************************************************
    // Quadrature counter, four counts per encoder pulse
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            enc_prev <= 2'h0;
            enc_count <= 32'sh0;
        end else begin
            enc_prev <= pin_sync[1:0];
            case ({enc_prev, pin_sync[1:0]})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                    enc_count <= enc_count + 32'sh1;
                end
                4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                    enc_count <= enc_count - 32'sh1;
                end
                default: begin
                    enc_count <= enc_count;
                end
            endcase
        end
    end

    // ****************************************************************
    // Operating state
    // ****************************************************************
    assign ref_mag = drive_in.freq_ref[15] ?
        16'(-drive_in.freq_ref) : drive_in.freq_ref;
    assign below_standstill = ref_mag < standstill_threshold_setting;

    always_comb begin
        next_state = state;
        case (state)
            ZSD_IDLE: begin
                if (pin_sync[2]) begin
                    next_state = ZSD_RUN;
                end
            end
            ZSD_RUN: begin
                if (!pin_sync[2]) begin
                    next_state = ZSD_IDLE;
                end else if (hold_cmd && below_standstill) begin
                    next_state = ZSD_HOLD;
                end
            end
            ZSD_HOLD: begin
                if (!pin_sync[2]) begin
                    next_state = ZSD_IDLE;
                end else if (!hold_cmd || !below_standstill) begin
                    next_state = ZSD_RUN;
                end
            end
            default: begin
                next_state = ZSD_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ZSD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            start_pos <= 32'sh0;
        end else if (next_state == ZSD_HOLD && state != ZSD_HOLD) begin
            start_pos <= enc_count;
        end
    end

    // ****************************************************************
    // Position hold loop
    // ****************************************************************
    // displacement in quad counts
    assign displacement = state == ZSD_HOLD ? enc_count - start_pos : 32'sh0;
    assign disp_mag = displacement[31] ? 32'(-displacement) : displacement;
    assign hold_prod = 48'(displacement) * $signed({32'h0,
        hold_loop_gain_setting});
    // width in quad counts; command off clears
    assign hold_done = state == ZSD_HOLD && hold_cmd &&
        disp_mag <= 32'(hold_window_setting);

    // ****************************************************************
    // Droop correction
    // ****************************************************************
    // zero disables droop
    assign droop_on = droop_disable_setting != 8'h00 && state == ZSD_RUN;

    // gain at max frequency and rated torque
    always_ff @(posedge clk) begin
        if (!resetn) begin
            droop_p1 <= 33'sh0;
            droop_p2 <= 50'sh0;
        end else begin
            droop_p1 <= $signed({1'b0, droop_gain_setting}) * drive_in.torque;
            droop_p2 <= 50'(droop_p1) * $signed({34'h0, max_freq_setting});
        end
    end
    assign droop_raw = droop_on ? zsd_clip16(droop_p2 / `ZSD_DROOP_DIV) :
        16'sh0000;

    zsd_lag_filter #(
        .CYC_PER_STEP(CYC_PER_STEP)
    ) u_lag (
        .clk(clk),
        .resetn(resetn),
        .clear(state == ZSD_IDLE),
        .delay_steps(droop_delay_setting),
        .sample(droop_raw),
        .filtered(droop_filt)
    );

    // ****************************************************************
    // Speed reference to the control core
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_out <= '0;
        end else begin
            drive_out.enable <= next_state != ZSD_IDLE;
            case (state)
                ZSD_RUN: begin
                    drive_out.speed_ref <= zsd_clip16(50'(drive_in.freq_ref) -
                        50'(droop_filt));
                end
                ZSD_HOLD: begin
                    drive_out.speed_ref <= zsd_clip16(-50'(hold_prod));
                end
                default: begin
                    drive_out.speed_ref <= 16'sh0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // APB slave; two-cycle access phase, pready from a register
    // ****************************************************************
    assign access = psel && penable && pready;

    always_comb begin
        read_ok = 1'b1;
        case (paddr)
            `ZSD_OFS_DROOP_GAIN: read_word = 32'(droop_gain_setting);
            `ZSD_OFS_DROOP_DELAY: read_word = 32'(droop_delay_setting);
            `ZSD_OFS_DROOP_DISABLE: read_word = 32'(droop_disable_setting);
            `ZSD_OFS_STANDSTILL: read_word = 32'(standstill_threshold_setting);
            `ZSD_OFS_HOLD_GAIN: read_word = 32'(hold_loop_gain_setting);
            `ZSD_OFS_HOLD_WINDOW: read_word = 32'(hold_window_setting);
            `ZSD_OFS_INPUT_SELECT: read_word = multifunction_input_select;
            `ZSD_OFS_OUTPUT_SELECT: read_word = multifunction_output_select;
            `ZSD_OFS_MAX_FREQ: read_word = 32'(max_freq_setting);
            `ZSD_OFS_STATUS: begin
                read_word = 32'h0;
                read_word[`ZSD_STAT_RUN] = state != ZSD_IDLE;
                read_word[`ZSD_STAT_HOLD] = state == ZSD_HOLD;
                read_word[`ZSD_STAT_DONE] = hold_done;
                read_word[`ZSD_STAT_DROOP] = droop_on;
                read_word[`ZSD_STAT_CMD] = hold_cmd;
            end
            `ZSD_OFS_DISPLACEMENT: read_word = displacement;
            `ZSD_OFS_SPEED_OUT: read_word = 32'(drive_out.speed_ref);
            default: begin
                read_word = 32'h0;
                read_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ?
                read_word : 32'h0;
            pslverr <= psel && penable && !pready && !read_ok;
        end
    end

    // Settings may change while running; the monitors ignore writes
    always_ff @(posedge clk) begin
        if (!resetn) begin
            droop_gain_setting <= `ZSD_RST_DROOP_GAIN;
            droop_delay_setting <= `ZSD_RST_DROOP_DELAY;
            droop_disable_setting <= `ZSD_RST_DROOP_DISABLE;
            standstill_threshold_setting <= `ZSD_RST_STANDSTILL;
            hold_loop_gain_setting <= `ZSD_RST_HOLD_GAIN;
            hold_window_setting <= `ZSD_RST_HOLD_WINDOW;
            multifunction_input_select <= `ZSD_RST_INPUT_SELECT;
            multifunction_output_select <= `ZSD_RST_OUTPUT_SELECT;
            max_freq_setting <= `ZSD_RST_MAX_FREQ;
        end else if (access && pwrite) begin
            case (paddr)
                `ZSD_OFS_DROOP_GAIN: droop_gain_setting <= pwdata[15:0];
                `ZSD_OFS_DROOP_DELAY: droop_delay_setting <= pwdata[15:0];
                `ZSD_OFS_DROOP_DISABLE: droop_disable_setting <= pwdata[7:0];
                `ZSD_OFS_STANDSTILL: begin
                    standstill_threshold_setting <= pwdata[15:0];
                end
                `ZSD_OFS_HOLD_GAIN: hold_loop_gain_setting <= pwdata[15:0];
                `ZSD_OFS_HOLD_WINDOW: hold_window_setting <= pwdata[15:0];
                `ZSD_OFS_INPUT_SELECT: multifunction_input_select <= pwdata;
                `ZSD_OFS_OUTPUT_SELECT: multifunction_output_select <= pwdata;
                `ZSD_OFS_MAX_FREQ: max_freq_setting <= pwdata[15:0];
                default: begin
                end
            endcase
        end
    end

endmodule : zsd_droop_servo

// ==== zsd_encoder_model.sv ====
/* Incremental encoder of the motor: one quadrature count per request.
   Assumes requests are spaced wide enough for the pin synchronisers. */
`timescale 1ns/1ps
module zsd_encoder_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Step requests
    input wire logic move,
    input wire logic up,
    // Quadrature lines
    output logic enc_a,
    output logic enc_b
);
    // ********
    // Shaft phase
    // ********
    logic [1:0] phase;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase <= 2'h0;
        end else if (move) begin
            phase <= up ? phase + 2'h1 : phase - 2'h1;
        end
    end
    // Gray order keeps A ahead of B when turning forward
    assign enc_b = phase[1];
    assign enc_a = phase[1] ^ phase[0];
endmodule : zsd_encoder_model

// ==== zsd_lag_filter.sv ====
/*
 * First-order lag for the droop correction.
 * Assumes the sample input is on the same clock; delay of zero passes
 * the input straight through one register.
 */
`timescale 1ns/1ps
`include "zsd_defines.svh"

module zsd_lag_filter #(
    parameter int CYC_PER_STEP = `ZSD_CYC_PER_STEP
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic clear,
    input wire logic [15:0] delay_steps,
    // Data
    input wire logic signed [15:0] sample,
    output logic signed [15:0] filtered
);
    import zsd_pkg::*;

    localparam int TICK = (CYC_PER_STEP >> `ZSD_FILTER_SHIFT) < 1 ?
        1 : (CYC_PER_STEP >> `ZSD_FILTER_SHIFT);

    logic [47:0] tick_count;
    logic [47:0] tick_limit;
    logic signed [16:0] error;

    assign tick_limit = 48'(delay_steps) * 48'(TICK);
    assign error = 17'(sample) - 17'(filtered);

    always_ff @(posedge clk) begin
        if (!resetn || clear || tick_count + 48'd1 >= tick_limit) begin
            tick_count <= 48'd0;
        end else begin
            tick_count <= tick_count + 48'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || clear) begin
            filtered <= 16'sh0000;
        end else if (delay_steps == 16'h0000) begin
            filtered <= sample;
        end else if (tick_count + 48'd1 >= tick_limit) begin
            // Step at least one count toward the sample so the output settles exactly
            if (error > 17'sd0 && (error >>> `ZSD_FILTER_SHIFT) == 17'sd0) begin
                filtered <= filtered + 16'sh0001;
            end else if (error < 17'sd0 &&
                         (error >>> `ZSD_FILTER_SHIFT) == -17'sd1) begin
                filtered <= filtered - 16'sh0001;
            end else begin
                filtered <= 16'(17'(filtered) +
                    (error >>> `ZSD_FILTER_SHIFT));
            end
        end
    end

endmodule : zsd_lag_filter

// ==== zsd_pkg.sv ====
/*
 * Types shared by the droop and zero-servo block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package zsd_pkg;

    // Operating state of the drive logic
    typedef enum logic [2:0] {
        ZSD_IDLE = 3'b001,
        ZSD_RUN  = 3'b010,
        ZSD_HOLD = 3'b100
    } zsd_state_type;

    // Reference and feedback from the control core, same clock
    typedef struct packed {
        logic signed [15:0] freq_ref;
        logic signed [15:0] torque;
    } zsd_drive_in_type;

    // Speed command back to the control core
    typedef struct packed {
        logic enable;
        logic signed [15:0] speed_ref;
    } zsd_drive_out_type;

endpackage : zsd_pkg
